// ---- rtl/rtg_core.sv ----
// rtg_core: always-on rtc logic: scratch word, fractional 1 Hz trim,
// hibernate entry/exit and low-frequency clock selection.
// assumes the oscillator, crystal and wake pin are asynchronous pins and
// that the register master sits on ref_clk.
//
// Contract
// - A 32-bit scratch word keeps whatever software writes.
// - The selected slow clock is divided by divider field plus one.
// - The trim interval is fixed at 1024 one-hertz periods.
// - Each interval drops as many input clocks as the delete count says.
// - A zero delete count drops nothing; divider sees raw clock.
// - Writing one to shutdown request enters hibernate and drops power enable.
// - An enabled wake event in hibernate asserts the hibernate reset.
// - In hibernate only wake logic and the rtc keep running; here interrupt status and its mask also stay live and writable.
// - Rtc clock is the oscillator or the main crystal divided by 512.
// - Select zero uses oscillator; select one, gate zero uses crystal/512.
// - Shutdown request clears on pin reset and on hibernate reset.
// - Wake flags clear on hibernate entry; the matching one sets on exit.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module rtg_core
  import rtg_pkg::*;
#(
  parameter int unsigned DIV_W = 16,
  parameter int unsigned HRST_CYC = HIB_RST_CYC
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire rtg_req_t req,
  output logic [31:0] rdata,
  // clock pins and gate from the clock manager
  input wire logic low_freq_oscillator,
  input wire logic main_crystal_clock,
  input wire logic divided_crystal_gate,
  // wake sources
  input wire logic wake_pin,
  input wire logic alarm_match,
  // power, reset, tick and interrupt outputs
  output logic power_enable_pin_n,
  output logic core_power_on,
  output logic hibernate_reset,
  output logic one_hz_tick,
  output logic irq
);
  logic [31:0] scratch_word_r;
  rtg_trim_t rtc_trim_register_r;
  logic shutdown_request_bit_r;
  logic external_clock_select_r;
  logic [1:0] wake_en_r;
  logic [1:0] wakeup_status_register_r;
  logic [1:0] irq_st_r;
  logic [1:0] irq_mask_r;
  logic [31:0] seconds_r;
  logic [2:0] osc_sync_r;
  logic [2:0] xtal_sync_r;
  logic [1:0] pin_sync_r;
  logic [8:0] xtal_cnt_r;
  logic xtal_tick;
  logic osc_tick;
  logic slow_tick;
  logic [DIV_W-1:0] pre_cnt_r;
  logic [9:0] period_cnt_r;
  logic [9:0] del_left_r;
  logic [7:0] hrst_cnt_r;
  logic wake_alarm;
  logic wake_pin_ev;
  logic wake_any;
  logic locked;

  function automatic logic hit(input rtg_req_t r, input logic [5:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // while powered down, only the interrupt status and its mask stay writable
  assign locked = shutdown_request_bit_r;

  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_sync_r <= 3'h7; // ones: a high pin after reset is no false rising edge
      xtal_sync_r <= 3'h7;
      pin_sync_r <= 2'h0;
    end
    else
    begin
      osc_sync_r <= {osc_sync_r[1:0], low_freq_oscillator};
      xtal_sync_r <= {xtal_sync_r[1:0], main_crystal_clock};
      pin_sync_r <= {pin_sync_r[0], wake_pin};
    end
  end

  // rising edges of the synchronised clocks, stages 1 and 2 only
  assign osc_tick = osc_sync_r[1] && !osc_sync_r[2];

  // crystal divided by 512 as an enable
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      xtal_cnt_r <= 9'h000;
    else if (xtal_sync_r[1] && !xtal_sync_r[2])
      xtal_cnt_r <= xtal_cnt_r + 9'h001;
  end
  assign xtal_tick = xtal_sync_r[1] && !xtal_sync_r[2] && (xtal_cnt_r == 9'(XTAL_DIV - 1));

  // source select; select=1 with gate=1 leaves the rtc without a clock
  always_comb
  begin
    if (!external_clock_select_r)
      slow_tick = osc_tick;
    else
      slow_tick = xtal_tick && !divided_crystal_gate;
  end

  // prescaler with clock deletion at the head of each trim interval
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pre_cnt_r <= '0;
      del_left_r <= RST_DEL;
    end
    else if (slow_tick)
    begin
      if (del_left_r != 10'h000)
        del_left_r <= del_left_r - 10'h001;
      else if (pre_cnt_r >= rtc_trim_register_r.div[DIV_W-1:0])
      begin
        pre_cnt_r <= '0;
        if (period_cnt_r == 10'(TRIM_PERIODS - 1))
          del_left_r <= rtc_trim_register_r.del_cnt;
      end
      else
        pre_cnt_r <= pre_cnt_r + DIV_W'(1);
    end
  end

  // one pulse per divided period; gated off while clocks are deleted
  assign one_hz_tick = slow_tick && (del_left_r == 10'h000)
    && (pre_cnt_r >= rtc_trim_register_r.div[DIV_W-1:0]);

  // trim interval and seconds counters keep running in hibernate
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      period_cnt_r <= 10'h000;
      seconds_r <= 32'h0000_0000;
    end
    else if (one_hz_tick)
    begin
      period_cnt_r <= period_cnt_r + 10'h001;
      seconds_r <= seconds_r + 32'h0000_0001;
    end
  end

  // wake sources, qualified by enables and by being asleep
  assign wake_alarm = alarm_match && wake_en_r[BIT_WAKE_ALARM];
  assign wake_pin_ev = pin_sync_r[1] && wake_en_r[BIT_WAKE_PIN];
  assign wake_any = shutdown_request_bit_r && (wake_alarm || wake_pin_ev);

  // shutdown request; wake or reset clears it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      shutdown_request_bit_r <= 1'b0;
    else if (wake_any)
      shutdown_request_bit_r <= 1'b0;
    else if (hit(req, OFS_HIB_CTRL) && req.wdata[BIT_SHUTDOWN])
      shutdown_request_bit_r <= 1'b1;
  end

  // power control: pin low keeps core and io supplied
  assign power_enable_pin_n = shutdown_request_bit_r;
  assign core_power_on = !shutdown_request_bit_r;

  // hibernate reset held for a fixed count after the wake event
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hrst_cnt_r <= 8'h00;
    else if (wake_any)
      hrst_cnt_r <= 8'(HRST_CYC);
    else if (hrst_cnt_r != 8'h00)
      hrst_cnt_r <= hrst_cnt_r - 8'h01;
  end
  assign hibernate_reset = (hrst_cnt_r != 8'h00);

  // wake cause flags: cleared on entry, set on exit, software writes 0 to clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wakeup_status_register_r <= 2'h0;
    else if (wake_any)
      wakeup_status_register_r <= {wake_pin_ev, wake_alarm};
    else if (hit(req, OFS_HIB_CTRL) && req.wdata[BIT_SHUTDOWN] && !locked)
      wakeup_status_register_r <= 2'h0;
    else if (hit(req, OFS_WAKE_ST) && !locked)
      wakeup_status_register_r <= wakeup_status_register_r & req.wdata[1:0];
  end

  // software registers; frozen while the chip is powered down
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scratch_word_r <= RST_SCRATCH;
      rtc_trim_register_r <= '{rsvd: 6'h00, del_cnt: RST_DEL, div: RST_DIV};
      external_clock_select_r <= 1'b0;
      wake_en_r <= 2'h0;
    end
    else if (!locked)
    begin
      if (hit(req, OFS_SCRATCH))
        scratch_word_r <= req.wdata;
      if (hit(req, OFS_TRIM))
        rtc_trim_register_r <= {6'h00, req.wdata[25:0]};
      if (hit(req, OFS_RTC_CTRL))
        external_clock_select_r <= req.wdata[BIT_EXT_SEL];
      if (hit(req, OFS_WAKE_EN))
        wake_en_r <= req.wdata[1:0];
    end
  end

  // interrupt status: set wins over a write-one clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_st_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~(hit(req, OFS_IRQ_ST) ? req.wdata[1:0] : 2'h0))
        | {wake_any, one_hz_tick};
      if (hit(req, OFS_IRQ_MASK))
        irq_mask_r <= req.wdata[1:0];
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);

  // read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (req.rd)
    begin
      case (req.addr)
        OFS_SCRATCH: rdata <= scratch_word_r;
        OFS_TRIM: rdata <= rtc_trim_register_r;
        OFS_HIB_CTRL: rdata <= {31'h0, shutdown_request_bit_r};
        OFS_RTC_CTRL: rdata <= {31'h0, external_clock_select_r};
        OFS_WAKE_EN: rdata <= {30'h0, wake_en_r};
        OFS_WAKE_ST: rdata <= {30'h0, wakeup_status_register_r};
        OFS_IRQ_ST: rdata <= {30'h0, irq_st_r};
        OFS_IRQ_MASK: rdata <= {30'h0, irq_mask_r};
        OFS_SECONDS: rdata <= seconds_r;
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

  // checks
  a_scratch_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !hit(req, OFS_SCRATCH) || locked |=> $stable(scratch_word_r))
    else $error("scratch word changed without a write");
  a_scratch_load: assert property (@(posedge ref_clk) disable iff (rst)
    hit(req, OFS_SCRATCH) && !locked |=> scratch_word_r == $past(req.wdata))
    else $error("scratch write did not land");
  a_div_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    one_hz_tick |=> pre_cnt_r == '0)
    else $error("prescaler did not wrap on the tick");
  a_trim_load: assert property (@(posedge ref_clk) disable iff (rst)
    one_hz_tick && period_cnt_r == 10'h3FF |=> del_left_r == $past(rtc_trim_register_r.del_cnt))
    else $error("delete count not loaded at interval end");
  a_del_block: assert property (@(posedge ref_clk) disable iff (rst)
    del_left_r != 10'h000 |-> !one_hz_tick)
    else $error("tick while clocks are being deleted");
  a_del_step: assert property (@(posedge ref_clk) disable iff (rst)
    slow_tick && del_left_r != 10'h000 |=> del_left_r == $past(del_left_r) - 10'h001
      && $stable(pre_cnt_r))
    else $error("deletion did not consume one input clock");
  a_no_trim: assert property (@(posedge ref_clk) disable iff (rst)
    del_left_r == 10'h000 && slow_tick && pre_cnt_r < rtc_trim_register_r.div
      |=> pre_cnt_r == $past(pre_cnt_r) + 1'b1)
    else $error("divider missed an undeleted clock");
  a_shutdown_pin: assert property (@(posedge ref_clk) disable iff (rst)
    hit(req, OFS_HIB_CTRL) && req.wdata[0] && !wake_any |=> power_enable_pin_n)
    else $error("power enable stayed active after shutdown write");
  a_wake_reset: assert property (@(posedge ref_clk) disable iff (rst)
    wake_any |=> hibernate_reset && !shutdown_request_bit_r ##1 hibernate_reset)
    else $error("wake did not raise hibernate reset");
  a_wake_flag: assert property (@(posedge ref_clk) disable iff (rst)
    wake_any && wake_alarm |=> wakeup_status_register_r[BIT_WAKE_ALARM])
    else $error("alarm wake flag not set on exit");
  a_clk_gated: assert property (@(posedge ref_clk) disable iff (rst)
    external_clock_select_r && divided_crystal_gate |=> $stable(pre_cnt_r) && $stable(del_left_r))
    else $error("rtc clocked through a closed gate");
endmodule

// ---- rtl/rtg_pkg.sv ----
// rtg_pkg: constants, register map and field layouts of the rtc trim,
// hibernate and clock-select block; shared by the design and the bench.
package rtg_pkg;
  // clock rate and derived counts
  localparam int unsigned REF_CLK_HZ = 40000000;
  localparam int unsigned REF_CLK_NS = 25;
  localparam int unsigned XTAL_DIV = 512;
  localparam int unsigned TRIM_PERIODS = 1024;
  localparam int unsigned HIB_RST_NS = 1000;
  localparam int unsigned HIB_RST_CYC = (HIB_RST_NS + REF_CLK_NS - 1) / REF_CLK_NS;

  // register byte offsets
  localparam logic [5:0] OFS_SCRATCH = 6'h00;
  localparam logic [5:0] OFS_TRIM = 6'h04;
  localparam logic [5:0] OFS_HIB_CTRL = 6'h08;
  localparam logic [5:0] OFS_RTC_CTRL = 6'h0C;
  localparam logic [5:0] OFS_WAKE_EN = 6'h10;
  localparam logic [5:0] OFS_WAKE_ST = 6'h14;
  localparam logic [5:0] OFS_IRQ_ST = 6'h18;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
  localparam logic [5:0] OFS_SECONDS = 6'h20;

  // field positions
  localparam int unsigned BIT_SHUTDOWN = 0;
  localparam int unsigned BIT_EXT_SEL = 0;
  localparam int unsigned BIT_WAKE_ALARM = 0;
  localparam int unsigned BIT_WAKE_PIN = 1;
  localparam int unsigned BIT_IRQ_TICK = 0;
  localparam int unsigned BIT_IRQ_WAKE = 1;

  // reset values
  localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
  localparam logic [15:0] RST_DIV = 16'h7FFF;
  localparam logic [9:0] RST_DEL = 10'h000;

  // trim register layout: divider in 15:0, delete count in 25:16
  typedef struct packed {
    logic [5:0] rsvd;
    logic [9:0] del_cnt;
    logic [15:0] div;
  } rtg_trim_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [31:0] wdata;
  } rtg_req_t;
endpackage

// ---- verif/rtg_power_side.sv ----
// rtg_power_side: external power switch and wake-up sources.
// assumes bench commands change just after a rising ref_clk edge.
`timescale 1ns/1ps
module rtg_power_side (
  // clock
  input wire logic ref_clk,
  // from the block
  input wire logic power_enable_pin_n,
  // bench commands
  input wire logic pin_req,
  input wire logic alarm_req,
  // to the block and the bench
  output logic wake_pin,
  output logic alarm_match,
  output logic supply_on
);
  // switch follows the pin at once: low keeps supplies on
  assign supply_on = !power_enable_pin_n;
  // wake line is a held level; alarm is a one-cycle pulse that repeats every other cycle while held
  always_ff @(posedge ref_clk)
  begin
    wake_pin <= pin_req;
    alarm_match <= alarm_req & !alarm_match;
  end
endmodule

// ---- verif/test_rtc_trim_hibernate_clock_select.sv ----
// test_rtc_trim_hibernate_clock_select: self-checking bench for rtg_core.
// assumes rtg_pkg is compiled first; oscillator and crystal made here.
`timescale 1ns/1ps
module test_rtc_trim_hibernate_clock_select;
  import rtg_pkg::*;
  logic ref_clk = 0, rst = 1, osc = 0, xtal = 0, gate = 0, pin_req = 0, alarm_req = 0;
  rtg_req_t req = '0;
  logic [31:0] rdata, rv;
  logic pwr_n, core_on, hrst, tick, irq, wpin, alarm_hit, sup;
  int num_errors = 0, n_tests = 0, seen = 0, g;

  rtg_core #(.HRST_CYC(4)) DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
    .low_freq_oscillator(osc), .main_crystal_clock(xtal), .divided_crystal_gate(gate),
    .wake_pin(wpin), .alarm_match(alarm_hit), .power_enable_pin_n(pwr_n),
    .core_power_on(core_on), .hibernate_reset(hrst), .one_hz_tick(tick), .irq(irq));
  rtg_power_side far (.ref_clk(ref_clk), .power_enable_pin_n(pwr_n), .pin_req(pin_req),
    .alarm_req(alarm_req), .wake_pin(wpin), .alarm_match(alarm_hit), .supply_on(sup));

  // 40 MHz clock; oscillator 8 cycles, crystal 4 cycles, slow enough for 2FF sampling
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always #100 osc = ~osc;
  always #50 xtal = ~xtal;

  task final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [5:0] a);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    req <= '0;
    #1 rv = rdata;
  endtask
  // cycles to the next tick, sampled on the falling edge to stay clear of updates
  task gap(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (tick !== 1'b1 && n < 9000);
    seen++;
    chk("tick_wait", 1, (n < 9000));
    if (n >= 9000)
      final_report();
  endtask
  task hrst_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (hrst !== 1'b1 && w < 20)
    begin
      @(negedge ref_clk);
      w++;
    end
    while (hrst === 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("wake_wait", 1, (w < 20));
    if (w >= 20)
      final_report();
  endtask

  task t_regs();
    rd(OFS_SCRATCH);
    chk("scratch_rst", RST_SCRATCH, rv);
    rd(OFS_TRIM);
    chk("trim_rst", 32'h0000_7FFF, rv);
    wr(OFS_SCRATCH, 32'hA5A5_5A5A);
    rd(OFS_SCRATCH);
    chk("scratch", 32'hA5A5_5A5A, rv);
    rd(6'h3C);
    chk("unmapped", 32'h0, rv);
  endtask
  // divider 1, oscillator selected with the gate closed: 2 slow edges per tick
  task t_trim();
    @(posedge ref_clk) gate <= 1'b1;
    wr(OFS_TRIM, 32'h0000_0001);
    gap(g);
    gap(g);
    chk("gap_raw", 16, g);
    wr(OFS_TRIM, 32'h0003_0001);
    while (seen < 1024)
      gap(g);
    chk("gap_1024", 16, g);
    gap(g);
    chk("gap_trim", 40, g);
    gap(g);
    chk("gap_after", 16, g);
    rd(OFS_SECONDS);
    chk("seconds", seen, rv);
  endtask
  // switch to crystal/512 in the documented order
  task t_xtal();
    @(posedge ref_clk) gate <= 1'b1;
    wr(OFS_RTC_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    gate <= 1'b0;
    rd(OFS_RTC_CTRL);
    chk("ext_sel", 32'h1, rv);
    gap(g);
    gap(g);
    chk("gap_xtal", 2 * XTAL_DIV * 4, g);
    @(posedge ref_clk) gate <= 1'b1;
    wr(OFS_RTC_CTRL, 32'h0);
    @(posedge ref_clk) gate <= 1'b0;
  endtask
  task t_hib();
    wr(OFS_IRQ_MASK, 32'h2);
    wr(OFS_WAKE_EN, 32'h1);
    rd(OFS_RTC_CTRL);
    chk("sel_before", 32'h0, rv);
    wr(OFS_HIB_CTRL, 32'h1);
    #1 chk("pin_n", 1, pwr_n);
    chk("core_on", 0, core_on);
    chk("supply", 0, sup);
    wr(OFS_SCRATCH, 32'h0);
    gap(g);
    gap(g);
    chk("gap_asleep", 16, g);
    @(posedge ref_clk) pin_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    pin_req <= 1'b0;
    chk("no_wake", 1, pwr_n);
    alarm_req <= 1'b1;
    @(posedge ref_clk) alarm_req <= 1'b0;
    hrst_len(g);
    chk("hrst_len", 4, g);
    chk("pin_wake", 0, pwr_n);
    rd(OFS_HIB_CTRL);
    chk("shutdown", 32'h0, rv);
    rd(OFS_WAKE_ST);
    chk("wake_alarm", 32'h1, rv);
    rd(OFS_IRQ_ST);
    chk("irq_st", 32'h2, rv & 32'h2);
    chk("irq_tick", 32'h1, rv & 32'h1);
    chk("irq_on", 1, irq);
    wr(OFS_IRQ_MASK, 32'h0);
    #1 chk("irq_masked", 0, irq);
    wr(OFS_IRQ_ST, 32'h2);
    wr(OFS_IRQ_MASK, 32'h2);
    #1 chk("irq_clear", 0, irq);
    wr(OFS_WAKE_EN, 32'h2);
    wr(OFS_HIB_CTRL, 32'h1);
    rd(OFS_WAKE_ST);
    chk("wake_entry", 32'h0, rv);
    @(posedge ref_clk) pin_req <= 1'b1;
    hrst_len(g);
    chk("hrst_pin", 4, g);
    @(posedge ref_clk) pin_req <= 1'b0;
    rd(OFS_WAKE_ST);
    chk("wake_pin", 32'h2, rv);
    chk("irq_pin", 1, irq);
    rd(OFS_SCRATCH);
    chk("scratch_kept", 32'hA5A5_5A5A, rv);
  endtask
  // pin reset in mid-run while asleep: power back on, shutdown and scratch cleared
  task t_rst();
    wr(OFS_WAKE_EN, 32'h0);
    wr(OFS_HIB_CTRL, 32'h1);
    #1 chk("pin_n_sleep", 1, pwr_n);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk("pin_n_rst", 0, pwr_n);
    chk("hrst_rst", 0, hrst);
    chk("irq_rst", 0, irq);
    rd(OFS_HIB_CTRL);
    chk("shutdown_rst", 32'h0, rv);
    rd(OFS_SCRATCH);
    chk("scratch_rst2", RST_SCRATCH, rv);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_trim();
    t_xtal();
    t_hib();
    t_rst();
    final_report();
  end
endmodule
